// *** tam_defines.svh ***
`ifndef TAM_DEFINES_SVH
`define TAM_DEFINES_SVH

// ==========================================================
// Pages
`define TAM_PAGE_RESULT 4'h0
`define TAM_PAGE_TOUCH 4'h1
`define TAM_PAGE_AUDIO 4'h2

// ==========================================================
// Page 0 result offsets
`define TAM_HORIZ_ADDR 6'h00
`define TAM_VERT_ADDR 6'h01
`define TAM_PRESS1_ADDR 6'h02
`define TAM_PRESS2_ADDR 6'h03
`define TAM_BATT1_ADDR 6'h05
`define TAM_BATT2_ADDR 6'h06
`define TAM_SPARE_ADDR 6'h07
`define TAM_THERM1_ADDR 6'h09
`define TAM_THERM2_ADDR 6'h0a
`define TAM_RESULT_W 12
`define TAM_RESULT_COUNT 11

// ==========================================================
// Page 1 control offsets
`define TAM_ADC_CTRL_ADDR 6'h00
`define TAM_STATUS_ADDR 6'h01
`define TAM_REFERENCE_ADDR 6'h03
`define TAM_SOFT_RESET_ADDR 6'h04
`define TAM_CONFIG_ADDR 6'h05
`define TAM_TOUCH_COUNT 6
`define TAM_PEN_DOWN_BIT 15
`define TAM_ADC_IDLE_BIT 14

// ==========================================================
// Page 2 audio offsets
`define TAM_AUDIO_CTRL1_ADDR 6'h00
`define TAM_VOLUME_ADDR 6'h02
`define TAM_AUDIO_CTRL2_ADDR 6'h04
`define TAM_POWER_ADDR 6'h05
`define TAM_AUDIO_CTRL3_ADDR 6'h06
`define TAM_COEF_FIRST_ADDR 6'h07
`define TAM_COEF_LAST_ADDR 6'h1a
`define TAM_PLL_FIRST_ADDR 6'h1b
`define TAM_PLL_LAST_ADDR 6'h1c
`define TAM_AUDIO_CTRL4_ADDR 6'h1d
`define TAM_AUDIO_DEPTH 32

// ==========================================================
// Pointer, words and reset values
`define TAM_PAGE_LAST 7'h1f
`define TAM_PTR_STOP 7'h40
`define TAM_PAST_END_WORD 16'hffff
`define TAM_RESET_WORD 16'h0000
`define TAM_WORD_LAST_BIT 4'hf

`endif

// *** tam_pkg.sv ***
`include "tam_defines.svh"

package tam_pkg;

  typedef enum logic [1:0] {
    TAM_IDLE = 2'b00,
    TAM_CMD = 2'b01,
    TAM_DATA = 2'b10
  } tam_state_t;

  typedef struct packed {
    logic rd;
    logic [3:0] page;
    logic [5:0] addr;
    logic [4:0] rsvd;
  } tam_cmd_t;

  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [11:0] value;
  } tam_result_t;

  typedef struct packed {
    logic [15:0] adc_ctrl;
    logic [15:0] status_cmd;
    logic [15:0] reference;
    logic [15:0] config_word;
  } tam_touch_ctrl_t;

  typedef struct packed {
    logic strobe;
    logic [5:0] index;
    logic [15:0] data;
  } tam_audio_wr_t;

  function automatic logic tam_is_result(input logic [5:0] a);
    return a == `TAM_HORIZ_ADDR || a == `TAM_VERT_ADDR || a == `TAM_PRESS1_ADDR ||
      a == `TAM_PRESS2_ADDR || a == `TAM_BATT1_ADDR || a == `TAM_BATT2_ADDR ||
      a == `TAM_SPARE_ADDR || a == `TAM_THERM1_ADDR || a == `TAM_THERM2_ADDR;
  endfunction

  function automatic logic tam_is_touch(input logic [5:0] a);
    return a == `TAM_ADC_CTRL_ADDR || a == `TAM_STATUS_ADDR || a == `TAM_REFERENCE_ADDR ||
      a == `TAM_SOFT_RESET_ADDR || a == `TAM_CONFIG_ADDR;
  endfunction

  function automatic logic tam_is_audio(input logic [5:0] a);
    return a == `TAM_AUDIO_CTRL1_ADDR || a == `TAM_VOLUME_ADDR ||
      a == `TAM_AUDIO_CTRL2_ADDR || a == `TAM_POWER_ADDR || a == `TAM_AUDIO_CTRL3_ADDR ||
      (a >= `TAM_COEF_FIRST_ADDR && a <= `TAM_COEF_LAST_ADDR) ||
      a == `TAM_PLL_FIRST_ADDR || a == `TAM_PLL_LAST_ADDR || a == `TAM_AUDIO_CTRL4_ADDR;
  endfunction

  function automatic logic [6:0] tam_ptr_inc(input logic [6:0] p);
    return (p >= `TAM_PTR_STOP) ? p : p + 7'h01;
  endfunction

endpackage

// *** tam_word_mem.sv ***
`timescale 1ns/100ps
`include "tam_defines.svh"
module tam_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = `TAM_AUDIO_DEPTH
) (
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic wr_en_i,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr_i,
  input wire logic [WIDTH-1:0] wr_data_i,
  input wire logic rd_en_i,
  input wire logic [$clog2(DEPTH)-1:0] rd_addr_i,
  output logic [WIDTH-1:0] rd_data_o
);
  logic [DEPTH-1:0][WIDTH-1:0] mem;

  if (DEPTH < 2 || WIDTH < 1) begin : g_bad
    $error("tam_word_mem: DEPTH must be at least 2 and WIDTH at least 1");
  end

  // Cleared on reset so every stored setting has a known value
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      mem <= '0;
      rd_data_o <= '0;
    end else begin
      if (wr_en_i) begin
        mem[wr_addr_i] <= wr_data_i;
      end
      if (rd_en_i) begin
        rd_data_o <= mem[rd_addr_i];
      end
    end
  end
endmodule

// *** tam_register_map.sv ***
// Function
// R1: Three pages of 16-bit registers: results on page 0, controls on pages 1, 2.
// R2: Page 0 results are read-only and return zero after any reset.
// R3: Results are right-justified 12 bits; bits 15 to 12 read zero.
// R4: Each conversion result lands in its own page 0 address.
// R5: Page 1 holds control 00, status 01, reference 03, reset 04, config 05.
// R6: Page 2 holds audio controls, volume, power, coefficients and synthesiser settings.
// R7: A control bit may mean status when read and command when written.
// R8: Command word: read bit, four page bits, six address bits, five zeros.
// R9: Burst pointer increments to page end; words beyond return all ones.
// R10: Writes to results or reserved addresses are ignored; reserved reads return zero.
`timescale 1ns/100ps
`include "tam_defines.svh"
module tam_register_map
  import tam_pkg::*;
(
  input wire logic clk_i,
  input wire logic arst_n_i,
  input wire logic sclk_i,
  input wire logic ss_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  input wire tam_result_t result_i,
  input wire logic pen_down_i,
  input wire logic adc_idle_i,
  input wire logic [15:0] status_word_i,
  output tam_touch_ctrl_t touch_ctrl_o,
  output tam_audio_wr_t audio_wr_o,
  output logic soft_reset_o
);

  // ==========================================================
  // Pin synchronisers
  logic [2:0] sclk_q, ss_q;
  logic [1:0] mosi_q;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sclk_q <= 3'h0;
      ss_q <= 3'h7;
      mosi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], sclk_i};
      ss_q <= {ss_q[1:0], ss_n_i};
      mosi_q <= {mosi_q[0], mosi_i};
    end
  end
  logic sclk_rise, sclk_fall, ss_fall, ss_active;
  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign ss_fall = ss_q[2] & ~ss_q[1];
  assign ss_active = ~ss_q[1];
  // ==========================================================
  // Serial frame engine
  tam_state_t state, next_state;
  logic [3:0] cnt, next_cnt, page, next_page;
  logic [15:0] rx, next_rx, tx, next_tx, rd_word, next_rd_word, wr_data, next_wr_data;
  logic [6:0] ptr, next_ptr;
  logic miso, next_miso, rd, next_rd, fetch, next_fetch, fetch_d, next_fetch_d, wr, next_wr;
  logic [10:0][11:0] res, next_res;
  logic [5:0][15:0] touch, next_touch;
  logic soft_reset, next_soft_reset, audio_we;
  tam_audio_wr_t audio_wr, next_audio_wr;
  logic [15:0] mem_q, read_val;
  // Word presented for the next read at the current pointer
  always_comb begin
    read_val = `TAM_RESET_WORD;
    if (ptr > `TAM_PAGE_LAST) begin
      read_val = `TAM_PAST_END_WORD; // R9
    end else begin
      case (page) // R1
        `TAM_PAGE_RESULT: begin
          if (tam_is_result(ptr[5:0])) begin
            read_val = {4'h0, res[ptr[3:0]]}; // R3
          end
        end
        `TAM_PAGE_TOUCH: begin
          if (ptr[5:0] == `TAM_ADC_CTRL_ADDR) begin
            read_val = touch[0];
            read_val[`TAM_PEN_DOWN_BIT] = pen_down_i; // R7
            read_val[`TAM_ADC_IDLE_BIT] = adc_idle_i; // R7
          end else if (ptr[5:0] == `TAM_STATUS_ADDR) begin
            read_val = status_word_i; // R7
          end else if (tam_is_touch(ptr[5:0])) begin
            read_val = touch[ptr[2:0]]; // R5
          end
        end
        `TAM_PAGE_AUDIO: begin
          if (tam_is_audio(ptr[5:0])) begin
            read_val = mem_q; // R6
          end
        end
        default: read_val = `TAM_RESET_WORD; // R10
      endcase
    end
  end
  always_comb begin
    tam_cmd_t cmd;
    logic [15:0] word;
    cmd = '0;
    word = {rx[14:0], mosi_q[1]};
    next_state = state;
    next_cnt = cnt;
    next_rx = rx;
    next_tx = tx;
    next_miso = miso;
    next_page = page;
    next_ptr = ptr;
    next_rd = rd;
    next_fetch = 1'b0;
    next_fetch_d = fetch;
    next_rd_word = fetch_d ? read_val : rd_word;
    next_wr = 1'b0;
    next_wr_data = wr_data;
    if (wr) begin
      next_ptr = tam_ptr_inc(ptr); // R9
    end
    if (ss_fall) begin
      next_state = TAM_CMD;
      next_cnt = 4'h0;
      next_miso = 1'b0;
    end else if (!ss_active) begin
      next_state = TAM_IDLE;
      next_miso = 1'b0;
    end else begin
      unique case (state)
        TAM_IDLE: next_state = TAM_IDLE;
        TAM_CMD: begin
          if (sclk_fall) begin
            next_rx = word;
            next_cnt = cnt + 4'h1;
            if (cnt == `TAM_WORD_LAST_BIT) begin
              cmd = word; // R8
              next_rd = cmd.rd;
              next_page = cmd.page;
              next_ptr = {1'b0, cmd.addr};
              next_fetch = cmd.rd;
              next_state = TAM_DATA;
            end
          end
        end
        TAM_DATA: begin
          if (sclk_rise && rd) begin
            next_miso = (cnt == 4'h0) ? rd_word[15] : tx[15];
            next_tx = {((cnt == 4'h0) ? rd_word[14:0] : tx[14:0]), 1'b0};
          end
          if (sclk_fall) begin
            next_rx = word;
            next_cnt = cnt + 4'h1;
            if (cnt == `TAM_WORD_LAST_BIT) begin
              if (rd) begin
                next_ptr = tam_ptr_inc(ptr); // R9
                next_fetch = 1'b1;
              end else begin
                next_wr = 1'b1;
                next_wr_data = word;
              end
            end
          end
        end
        default: next_state = TAM_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= TAM_IDLE;
      cnt <= 4'h0;
      rx <= 16'h0000;
      tx <= 16'h0000;
      miso <= 1'b0;
      page <= 4'h0;
      ptr <= 7'h00;
      rd <= 1'b0;
      fetch <= 1'b0;
      fetch_d <= 1'b0;
      rd_word <= 16'h0000;
      wr <= 1'b0;
      wr_data <= 16'h0000;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      rx <= next_rx;
      tx <= next_tx;
      miso <= next_miso;
      page <= next_page;
      ptr <= next_ptr;
      rd <= next_rd;
      fetch <= next_fetch;
      fetch_d <= next_fetch_d;
      rd_word <= next_rd_word;
      wr <= next_wr;
      wr_data <= next_wr_data;
    end
  end
  assign miso_o = miso;
  assign miso_oe_o = (state != TAM_IDLE);
  // ==========================================================
  // Register storage
  assign audio_we = wr && page == `TAM_PAGE_AUDIO && ptr <= `TAM_PAGE_LAST &&
    tam_is_audio(ptr[5:0]);
  always_comb begin
    next_res = soft_reset ? '0 : res; // R2
    next_touch = touch;
    next_soft_reset = 1'b0;
    next_audio_wr = '0;
    if (result_i.valid && tam_is_result(result_i.index)) begin
      next_res[result_i.index[3:0]] = result_i.value; // R4
    end
    if (wr && page == `TAM_PAGE_TOUCH && ptr <= `TAM_PAGE_LAST &&
        tam_is_touch(ptr[5:0])) begin
      next_touch[ptr[2:0]] = wr_data; // R5
      next_soft_reset = (ptr[5:0] == `TAM_SOFT_RESET_ADDR);
    end
    if (audio_we) begin
      next_audio_wr = '{strobe: 1'b1, index: ptr[5:0], data: wr_data}; // R6
    end
  end
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      res <= '0;
      touch <= '0;
      soft_reset <= 1'b0;
      audio_wr <= '0;
    end else begin
      res <= next_res;
      touch <= next_touch;
      soft_reset <= next_soft_reset;
      audio_wr <= next_audio_wr;
    end
  end
  assign touch_ctrl_o = '{adc_ctrl: touch[0], status_cmd: touch[1],
    reference: touch[3], config_word: touch[5]};
  assign audio_wr_o = audio_wr;
  assign soft_reset_o = soft_reset;
  tam_word_mem #(
    .WIDTH(16),
    .DEPTH(`TAM_AUDIO_DEPTH)
  ) u_audio_mem (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .wr_en_i(audio_we),
    .wr_addr_i(ptr[4:0]),
    .wr_data_i(wr_data),
    .rd_en_i(fetch),
    .rd_addr_i(ptr[4:0]),
    .rd_data_o(mem_q)
  );
  // ==========================================================
  // Checks
  a_result_upper_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R3
    fetch_d && page == `TAM_PAGE_RESULT && ptr <= `TAM_PAGE_LAST |=> rd_word[15:12] == 4'h0)
    else $error("result word upper bits not zero");
  a_past_end_ones: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
    fetch_d && ptr > `TAM_PAGE_LAST |=> rd_word == `TAM_PAST_END_WORD)
    else $error("word beyond page end not all ones");
  a_cmd_decode: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R8
    ss_active && !ss_fall && state == TAM_CMD && sclk_fall && cnt == `TAM_WORD_LAST_BIT
    |=> state == TAM_DATA && ptr[5:0] == $past(rx[9:4]) && page == $past(rx[13:10])
    && rd == $past(rx[14]))
    else $error("command word decoded wrongly");
  a_read_increment: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
    ss_active && !ss_fall && state == TAM_DATA && rd && sclk_fall &&
    cnt == `TAM_WORD_LAST_BIT && ptr < `TAM_PTR_STOP |=> ptr == $past(ptr) + 7'h01 ##1 fetch_d)
    else $error("burst pointer did not advance");
  a_reserved_read_zero: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R10
    fetch_d && page == `TAM_PAGE_RESULT && ptr <= `TAM_PAGE_LAST &&
    !tam_is_result(ptr[5:0]) |=> rd_word == `TAM_RESET_WORD)
    else $error("reserved address read not zero");
  a_result_readonly: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    wr && page == `TAM_PAGE_RESULT && !result_i.valid && !soft_reset |=> $stable(res))
    else $error("host write changed a result");
  a_result_store: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R4
    result_i.valid && tam_is_result(result_i.index)
    |=> res[$past(result_i.index[3:0])] == $past(result_i.value))
    else $error("conversion result not stored");
  a_soft_reset_clear: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R2
    soft_reset && !result_i.valid |=> res == '0)
    else $error("soft reset did not clear results");
  a_touch_write: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R5
    wr && page == `TAM_PAGE_TOUCH && ptr == {1'b0, `TAM_CONFIG_ADDR}
    |=> touch_ctrl_o.config_word == $past(wr_data))
    else $error("configuration write lost");
  a_status_read: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R7
    fetch_d && page == `TAM_PAGE_TOUCH && ptr == {1'b0, `TAM_ADC_CTRL_ADDR}
    |=> rd_word[15:14] == $past({pen_down_i, adc_idle_i}))
    else $error("status bits not shown on read");
  a_audio_strobe: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R6
    audio_we |=> audio_wr_o.strobe && audio_wr_o.data == $past(wr_data) ##1 !audio_wr_o.strobe)
    else $error("audio write strobe wrong");
  a_miso_first: assert property (@(posedge clk_i) disable iff (!arst_n_i) // R9
    ss_active && !ss_fall && state == TAM_DATA && rd && sclk_rise && cnt == 4'h0
    |=> miso_o == $past(rd_word[15]))
    else $error("first data bit not driven");
endmodule

// *** tam_host_model.sv ***
`timescale 1ns/100ps
module tam_host_model (
  input wire logic clk_i,
  output logic sclk_o,
  output logic ss_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  // ==========================================================
  // Idle levels: clock parked low, select high
  initial begin
    sclk_o = 1'b0;
    ss_n_o = 1'b1;
    mosi_o = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  // ==========================================================
  // One frame: command word, then n data words, MSB first
  task automatic xfer(input logic [15:0] cmd, input int n, input logic [15:0] wd[32],
                      output logic [15:0] rd[32]);
    logic [15:0] word;
    wait_clk(1);
    ss_n_o = 1'b0;
    wait_clk(6);
    for (int k = 0; k <= n; k++) begin
      word = (k == 0) ? cmd : wd[k-1];
      for (int b = 15; b >= 0; b--) begin
        sclk_o = 1'b1;
        mosi_o = word[b];
        wait_clk(6);
        if (k > 0) begin
          rd[k-1][b] = miso_i;
        end
        sclk_o = 1'b0;
        wait_clk(6);
      end
    end
    ss_n_o = 1'b1;
    // Released data line must not keep its last level
    mosi_o = ~mosi_o;
    wait_clk(6);
  endtask
endmodule

// *** tam_register_map_tb.sv ***
`timescale 1ns/100ps
module tam_register_map_tb;
  import tam_pkg::*;
  logic clk;
  logic arst_n;
  logic sclk;
  logic ss_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic pen_down;
  logic adc_idle;
  logic soft_reset;
  logic [15:0] status_word;
  tam_result_t result;
  tam_touch_ctrl_t touch_ctrl;
  tam_audio_wr_t audio_wr;
  logic [15:0] wd[32];
  logic [15:0] rd[32];
  int error_cnt = 0;
  int tests_run = 0;
  int soft_cnt = 0;
  int audio_cnt = 0;

  tam_register_map DUT (.clk_i(clk), .arst_n_i(arst_n), .sclk_i(sclk), .ss_n_i(ss_n),
    .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe), .result_i(result),
    .pen_down_i(pen_down), .adc_idle_i(adc_idle), .status_word_i(status_word),
    .touch_ctrl_o(touch_ctrl), .audio_wr_o(audio_wr), .soft_reset_o(soft_reset));

  tam_host_model u_host (.clk_i(clk), .sclk_o(sclk), .ss_n_o(ss_n), .mosi_o(mosi),
    .miso_i(miso));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ==========================================================
  // Reporting
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up;
    $display("errors=%0d checks=%0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    error_cnt++;
    wrap_up();
  end

  function automatic logic [15:0] cmd_word(input logic r, input logic [3:0] pg,
                                           input logic [5:0] a);
    return {r, pg, a, 5'h00};
  endfunction

  // Burst read from pg/a, compares against expected words in exp
  task automatic rd_chk(input logic [3:0] pg, input logic [5:0] a, input int n,
                        input logic [15:0] exp[32]);
    u_host.xfer(cmd_word(1'b1, pg, a), n, wd, rd);
    for (int k = 0; k < n; k++) begin
      check(rd[k], exp[k]);
    end
  endtask

  // ==========================================================
  // Monitor of pulsed outputs
  always @(negedge clk) begin
    if (soft_reset === 1'b1) begin
      soft_cnt++;
    end
    if (audio_wr.strobe === 1'b1) begin
      audio_cnt++;
      check(audio_wr.data, 16'h2000 | {10'h000, audio_wr.index});
    end
    // Output enable must stand throughout every clocked part of a frame
    if (ss_n === 1'b0 && sclk === 1'b1) begin
      check({15'h0000, miso_oe}, 16'h0001);
    end
  end

  // ==========================================================
  // Scenarios
  task automatic t_reset;
    logic [15:0] e[32];
    check({15'h0000, miso_oe}, 16'h0000);
    check(touch_ctrl.adc_ctrl | touch_ctrl.reference | touch_ctrl.config_word, 16'h0000);
    for (int k = 0; k < 32; k++) begin
      e[k] = 16'h0000;
    end
    rd_chk(4'h0, 6'h00, 11, e);
    e[2] = 16'hffff;
    rd_chk(4'h1, 6'h1e, 3, e);
    rd_chk(4'h3, 6'h00, 1, e);
  endtask

  task automatic t_results;
    logic [15:0] e[32];
    for (int a = 0; a < 11; a++) begin
      result = '{1'b1, 6'(a), {6'h2a, 6'(a)}};
      @(negedge clk);
    end
    result = '0;
    for (int a = 0; a < 11; a++) begin
      e[a] = (a == 4 || a == 8) ? 16'h0000 : {4'h0, 6'h2a, 6'(a)};
    end
    rd_chk(4'h0, 6'h00, 11, e);
    wd[0] = 16'hffff;
    u_host.xfer(cmd_word(1'b0, 4'h0, 6'h01), 1, wd, rd);
    e[0] = e[1];
    rd_chk(4'h0, 6'h01, 1, e);
  endtask

  task automatic t_touch;
    logic [15:0] e[32];
    pen_down = 1'b0;
    adc_idle = 1'b1;
    status_word = 16'h5a5a;
    for (int k = 0; k < 6; k++) begin
      wd[k] = 16'h8c50 + 16'(k);
    end
    u_host.xfer(cmd_word(1'b0, 4'h1, 6'h00), 6, wd, rd);
    check(16'(soft_cnt), 16'h0001);
    check(touch_ctrl.adc_ctrl, 16'h8c50);
    check(touch_ctrl.status_cmd, 16'h8c51);
    check(touch_ctrl.reference, 16'h8c53);
    check(touch_ctrl.config_word, 16'h8c55);
    e = '{default: 16'h0000};
    e[0] = 16'h4c50;
    e[1] = 16'h5a5a;
    e[3] = 16'h8c53;
    e[4] = 16'h8c54;
    e[5] = 16'h8c55;
    rd_chk(4'h1, 6'h00, 6, e);
    e[0] = 16'h0000;
    rd_chk(4'h0, 6'h00, 1, e);
  endtask

  task automatic t_audio;
    logic [15:0] e[32];
    for (int k = 0; k < 32; k++) begin
      wd[k] = 16'h2000 | 16'(k);
    end
    u_host.xfer(cmd_word(1'b0, 4'h2, 6'h00), 32, wd, rd);
    check(16'(audio_cnt), 16'h001c);
    e = '{default: 16'h0000};
    e[0] = 16'h201d;
    e[3] = 16'hffff;
    rd_chk(4'h2, 6'h1d, 4, e);
    e[0] = 16'h2000;
    e[2] = 16'h2002;
    rd_chk(4'h2, 6'h00, 3, e);
  endtask

  initial begin
    arst_n = 1'b0;
    result = '0;
    pen_down = 1'b0;
    adc_idle = 1'b0;
    status_word = 16'h0000;
    wd = '{default: 16'h0000};
    repeat (10) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_reset();
    t_results();
    t_touch();
    t_audio();
    wrap_up();
  end
endmodule
